// [rtl/line_monitor_pkg.sv]
package line_monitor_pkg;

    // Widths of the sample path, the register port and the result store.
    localparam int RAW_W       = 24;
    localparam int CODE_W      = 8;
    localparam int ADDR_W      = 8;
    localparam int WORD_W      = 4;
    localparam int WORDS       = 16;
    localparam int SEL_W       = 3;
    localparam int RECIP_SHIFT = 24;
    localparam int PROD_W      = RAW_W + RECIP_SHIFT;

    // Byte offsets of the readback registers.
    localparam logic [ADDR_W-1:0] POWER_OFFSET         = 8'h4d;
    localparam logic [ADDR_W-1:0] LOOP_V_OFFSET        = 8'h4e;
    localparam logic [ADDR_W-1:0] LOOP_I_OFFSET        = 8'h4f;
    localparam logic [ADDR_W-1:0] TIP_V_OFFSET         = 8'h50;
    localparam logic [ADDR_W-1:0] RING_V_OFFSET        = 8'h51;
    localparam logic [ADDR_W-1:0] BATTERY_A_OFFSET     = 8'h52;
    localparam logic [ADDR_W-1:0] BATTERY_B_OFFSET     = 8'h53;
    localparam logic [ADDR_W-1:0] FIRST_CURRENT_OFFSET = 8'h54;

    // Word slots in the result store; the six power results sit from the bank base up.
    localparam logic [WORD_W-1:0] LOOP_V_WORD        = 4'h1;
    localparam logic [WORD_W-1:0] LOOP_I_WORD        = 4'h2;
    localparam logic [WORD_W-1:0] TIP_V_WORD         = 4'h3;
    localparam logic [WORD_W-1:0] RING_V_WORD        = 4'h4;
    localparam logic [WORD_W-1:0] BATTERY_A_WORD     = 4'h5;
    localparam logic [WORD_W-1:0] BATTERY_B_WORD     = 4'h6;
    localparam logic [WORD_W-1:0] FIRST_CURRENT_WORD = 4'h7;
    localparam logic [WORD_W-1:0] POWER_BANK_WORD    = 4'h8;
    localparam logic [SEL_W-1:0]  SELECT_LAST        = 3'h5;

    // Reset values, read values and code layout.
    localparam logic [CODE_W-1:0] RESET_CODE    = 8'h00;
    localparam logic [CODE_W-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [CODE_W-1:0] CODE_FULL     = 8'hff;
    localparam logic [CODE_W-1:0] MAG_FULL      = 8'h3f;
    localparam int                SIGN_BIT      = 6;
    localparam int                MAG_MSB       = 5;

    // Raw sample units: power in 10 uW, voltage in mV, current in uA.
    localparam real POWER_UNIT_MW   = 0.01;
    localparam real VOLT_UNIT_V     = 0.001;
    localparam real CURRENT_UNIT_MA = 0.001;

    // Code steps as printed, and the same steps in raw units.
    localparam real POWER_HI_STEP_MW = 30.4;
    localparam real POWER_LO_STEP_MW = 3.62;
    localparam real LOOP_V_STEP_V    = 1.5;
    localparam real LOOP_I_STEP_MA   = 1.25;
    localparam real NODE_V_STEP_V    = 0.376;
    localparam real FIRST_I_STEP_MA  = 0.319;
    localparam int POWER_HI_STEP_RAW = int'(POWER_HI_STEP_MW / POWER_UNIT_MW);
    localparam int POWER_LO_STEP_RAW = int'(POWER_LO_STEP_MW / POWER_UNIT_MW);
    localparam int LOOP_V_STEP_RAW   = int'(LOOP_V_STEP_V / VOLT_UNIT_V);
    localparam int LOOP_I_STEP_RAW   = int'(LOOP_I_STEP_MA / CURRENT_UNIT_MA);
    localparam int NODE_V_STEP_RAW   = int'(NODE_V_STEP_V / VOLT_UNIT_V);
    localparam int FIRST_I_STEP_RAW  = int'(FIRST_I_STEP_MA / CURRENT_UNIT_MA);

    // Scaling multiplies by a rounded-up reciprocal instead of dividing.
    function automatic logic [RAW_W-1:0] recip_of(input int step_raw);
        return RAW_W'(((2 ** RECIP_SHIFT) + step_raw - 1) / step_raw);
    endfunction

    localparam logic [RAW_W-1:0] POWER_HI_RECIP = recip_of(POWER_HI_STEP_RAW);
    localparam logic [RAW_W-1:0] POWER_LO_RECIP = recip_of(POWER_LO_STEP_RAW);
    localparam logic [RAW_W-1:0] LOOP_V_RECIP   = recip_of(LOOP_V_STEP_RAW);
    localparam logic [RAW_W-1:0] LOOP_I_RECIP   = recip_of(LOOP_I_STEP_RAW);
    localparam logic [RAW_W-1:0] NODE_V_RECIP   = recip_of(NODE_V_STEP_RAW);
    localparam logic [RAW_W-1:0] FIRST_I_RECIP  = recip_of(FIRST_I_STEP_RAW);

    typedef enum logic [3:0] {
        CH_POWER_Q1, CH_POWER_Q2, CH_POWER_Q3, CH_POWER_Q4, CH_POWER_Q5, CH_POWER_Q6,
        CH_LOOP_V, CH_LOOP_I, CH_TIP_V, CH_RING_V, CH_BATTERY_A, CH_BATTERY_B,
        CH_FIRST_CURRENT, CH_EXT_BIAS
    } channel_type;

    typedef enum logic [1:0] {MAG_POSITIVE, MAG_NEGATIVE, MAG_SIGNED} polarity_type;

    typedef struct packed {
        logic                    valid;
        channel_type             channel;
        logic signed [RAW_W-1:0] value;
    } sample_type;

    typedef struct packed {
        logic              write;
        logic              read;
        logic [ADDR_W-1:0] addr;
        logic [CODE_W-1:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] idx;
        logic              signed_fmt;
        logic              sign;
        logic [RAW_W-1:0]  magnitude;
        logic [RAW_W-1:0]  recip;
        logic [CODE_W-1:0] limit;
    } scale_req_type;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] idx;
        logic [CODE_W-1:0] data;
    } mem_write_type;

endpackage

// [rtl/measurement_scaler.sv]
module measurement_scaler (
    input  wire logic                           clk_in,
    input  wire logic                           rstn_in,
    input  wire line_monitor_pkg::scale_req_type req_in,
    output line_monitor_pkg::mem_write_type      write_out
);

    typedef struct packed {
        line_monitor_pkg::mem_write_type result;
    } scaler_state_type;

    scaler_state_type state_reg;
    scaler_state_type state_next;

    // Multiply by the reciprocal, saturate at the request's limit and, in signed format, pack sign and magnitude.
    always_comb begin
        logic [line_monitor_pkg::PROD_W-1:0] product;
        logic [line_monitor_pkg::RAW_W-1:0]  whole;
        logic [line_monitor_pkg::CODE_W-1:0] code;
        product = '0;
        whole = '0;
        code = '0;
        state_next = state_reg;
        product = line_monitor_pkg::PROD_W'(req_in.magnitude) *
                  line_monitor_pkg::PROD_W'(req_in.recip);
        whole = product[line_monitor_pkg::PROD_W-1:line_monitor_pkg::RECIP_SHIFT];
        if (whole > line_monitor_pkg::RAW_W'(req_in.limit)) begin
            code = req_in.limit;
        end else begin
            code = whole[line_monitor_pkg::CODE_W-1:0];
        end
        state_next.result.valid = req_in.valid;
        state_next.result.idx   = req_in.idx;
        if (req_in.signed_fmt) begin
            state_next.result.data = {1'b0, req_in.sign, code[line_monitor_pkg::MAG_MSB:0]};
        end else begin
            state_next.result.data = code;
        end
    end

    // One pipeline register.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign write_out = state_reg.result;

endmodule

// [rtl/measurement_store.sv]
module measurement_store (
    input  wire logic                                 clk_in,
    input  wire logic                                 rstn_in,
    input  wire line_monitor_pkg::mem_write_type       write_in,
    input  wire logic                                 read_in,
    input  wire logic                                 hit_in,
    input  wire logic [line_monitor_pkg::WORD_W-1:0]  idx_in,
    output logic [line_monitor_pkg::CODE_W-1:0]       rdata_out
);

    typedef struct packed {
        logic [line_monitor_pkg::WORDS-1:0][line_monitor_pkg::CODE_W-1:0] words;
        logic [line_monitor_pkg::CODE_W-1:0]                              rdata;
    } store_state_type;

    store_state_type state_reg;
    store_state_type state_next;

    // Latest result per slot; read data stand for one cycle only, zero otherwise.
    always_comb begin
        state_next = state_reg;
        if (write_in.valid) begin
            state_next.words[write_in.idx] = write_in.data;
        end
        if (read_in && hit_in) begin
            state_next.rdata = state_reg.words[idx_in];
        end else begin
            state_next.rdata = line_monitor_pkg::UNMAPPED_READ;
        end
    end

    // All slots start at the reset code.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;

endmodule

// [rtl/line_monitor_readback.sv]
// The implementer's own choice: the plain strobed port.
module line_monitor_readback (
    input  wire logic                                 clk_in,
    input  wire logic                                 rstn_in,
    input  wire line_monitor_pkg::reg_req_type         reg_req_in,
    output logic [line_monitor_pkg::CODE_W-1:0]       reg_rdata_out,
    input  wire line_monitor_pkg::sample_type          sample_in,
    input  wire logic [line_monitor_pkg::SEL_W-1:0]   power_monitor_select_in,
    input  wire logic                                 extended_bias_enable_in
);

    typedef struct packed {
        logic                                valid;
        logic [line_monitor_pkg::WORD_W-1:0] idx;
        logic [line_monitor_pkg::RAW_W-1:0]  recip;
        logic [line_monitor_pkg::CODE_W-1:0] limit;
        line_monitor_pkg::polarity_type      polarity;
    } channel_cfg_type;

    typedef struct packed {
        logic                                hit;
        logic [line_monitor_pkg::WORD_W-1:0] idx;
    } read_map_type;

    typedef struct packed {
        line_monitor_pkg::scale_req_type    stage;
        logic [line_monitor_pkg::RAW_W-1:0] extended_bias_current;
    } monitor_state_type;

    monitor_state_type                 state_reg;
    monitor_state_type                 state_next;
    line_monitor_pkg::mem_write_type   scaled_write;
    read_map_type                      read_map;

    // Per-channel destination slot, scale and sign handling.
    function automatic channel_cfg_type channel_map(input line_monitor_pkg::channel_type ch);
        channel_cfg_type cfg;
        cfg = '0;
        cfg.valid = 1'b1;
        cfg.limit = line_monitor_pkg::CODE_FULL;
        cfg.polarity = line_monitor_pkg::MAG_NEGATIVE;
        cfg.recip = line_monitor_pkg::NODE_V_RECIP;
        unique case (ch)
            line_monitor_pkg::CH_POWER_Q1, line_monitor_pkg::CH_POWER_Q2,
            line_monitor_pkg::CH_POWER_Q5, line_monitor_pkg::CH_POWER_Q6: begin
                cfg.idx = line_monitor_pkg::POWER_BANK_WORD + line_monitor_pkg::WORD_W'(ch);
                cfg.recip = line_monitor_pkg::POWER_HI_RECIP;
                cfg.polarity = line_monitor_pkg::MAG_POSITIVE;
            end
            line_monitor_pkg::CH_POWER_Q3, line_monitor_pkg::CH_POWER_Q4: begin
                cfg.idx = line_monitor_pkg::POWER_BANK_WORD + line_monitor_pkg::WORD_W'(ch);
                cfg.recip = line_monitor_pkg::POWER_LO_RECIP;
                cfg.polarity = line_monitor_pkg::MAG_POSITIVE;
            end
            line_monitor_pkg::CH_LOOP_V: begin
                cfg.idx = line_monitor_pkg::LOOP_V_WORD;
                cfg.recip = line_monitor_pkg::LOOP_V_RECIP;
                cfg.limit = line_monitor_pkg::MAG_FULL;
                cfg.polarity = line_monitor_pkg::MAG_SIGNED;
            end
            line_monitor_pkg::CH_LOOP_I: begin
                cfg.idx = line_monitor_pkg::LOOP_I_WORD;
                cfg.recip = line_monitor_pkg::LOOP_I_RECIP;
                cfg.limit = line_monitor_pkg::MAG_FULL;
                cfg.polarity = line_monitor_pkg::MAG_SIGNED;
            end
            line_monitor_pkg::CH_TIP_V: begin
                cfg.idx = line_monitor_pkg::TIP_V_WORD;
            end
            line_monitor_pkg::CH_RING_V: begin
                cfg.idx = line_monitor_pkg::RING_V_WORD;
            end
            line_monitor_pkg::CH_BATTERY_A: begin
                cfg.idx = line_monitor_pkg::BATTERY_A_WORD;
            end
            line_monitor_pkg::CH_BATTERY_B: begin
                cfg.idx = line_monitor_pkg::BATTERY_B_WORD;
            end
            line_monitor_pkg::CH_FIRST_CURRENT: begin
                cfg.idx = line_monitor_pkg::FIRST_CURRENT_WORD;
                cfg.recip = line_monitor_pkg::FIRST_I_RECIP;
                cfg.polarity = line_monitor_pkg::MAG_POSITIVE;
            end
            line_monitor_pkg::CH_EXT_BIAS: begin
                cfg.valid = 1'b0;
                cfg.polarity = line_monitor_pkg::MAG_POSITIVE;
            end
            default: begin
                cfg.valid = 1'b0;
            end
        endcase
        return cfg;
    endfunction

    // Magnitude of a sample that is only meaningful on one side of zero.
    function automatic logic [line_monitor_pkg::RAW_W-1:0] one_sided(
        input logic signed [line_monitor_pkg::RAW_W-1:0] value,
        input logic                                      negative_side
    );
        logic [line_monitor_pkg::RAW_W-1:0] mag;
        mag = '0;
        if (negative_side && value < 0) begin
            mag = line_monitor_pkg::RAW_W'(-value);
        end else if (!negative_side && value > 0) begin
            mag = line_monitor_pkg::RAW_W'(value);
        end
        return mag;
    endfunction

    // Register offset to result slot; the power offset follows the live pointer.
    function automatic read_map_type decode_offset(
        input logic [line_monitor_pkg::ADDR_W-1:0] addr,
        input logic [line_monitor_pkg::SEL_W-1:0]  sel
    );
        read_map_type map;
        map.hit = 1'b1;
        map.idx = '0;
        unique case (addr)
            line_monitor_pkg::POWER_OFFSET: begin
                map.hit = (sel <= line_monitor_pkg::SELECT_LAST);
                map.idx = line_monitor_pkg::POWER_BANK_WORD + line_monitor_pkg::WORD_W'(sel);
            end
            line_monitor_pkg::LOOP_V_OFFSET: begin
                map.idx = line_monitor_pkg::LOOP_V_WORD;
            end
            line_monitor_pkg::LOOP_I_OFFSET: begin
                map.idx = line_monitor_pkg::LOOP_I_WORD;
            end
            line_monitor_pkg::TIP_V_OFFSET: begin
                map.idx = line_monitor_pkg::TIP_V_WORD;
            end
            line_monitor_pkg::RING_V_OFFSET: begin
                map.idx = line_monitor_pkg::RING_V_WORD;
            end
            line_monitor_pkg::BATTERY_A_OFFSET: begin
                map.idx = line_monitor_pkg::BATTERY_A_WORD;
            end
            line_monitor_pkg::BATTERY_B_OFFSET: begin
                map.idx = line_monitor_pkg::BATTERY_B_WORD;
            end
            line_monitor_pkg::FIRST_CURRENT_OFFSET: begin
                map.idx = line_monitor_pkg::FIRST_CURRENT_WORD;
            end
            default: begin
                map.hit = 1'b0;
            end
        endcase
        return map;
    endfunction

    // Turn each converter sample into a scaling request and track the bias current.
    always_comb begin
        channel_cfg_type                    cfg;
        logic [line_monitor_pkg::RAW_W-1:0] mag;
        cfg = channel_map(sample_in.channel);
        mag = '0;
        state_next = state_reg;
        unique case (cfg.polarity)
            line_monitor_pkg::MAG_SIGNED: begin
                mag = one_sided(sample_in.value, sample_in.value < 0);
            end
            line_monitor_pkg::MAG_NEGATIVE: begin
                mag = one_sided(sample_in.value, 1'b1);
            end
            default: begin
                mag = one_sided(sample_in.value, 1'b0);
            end
        endcase
        if (sample_in.channel == line_monitor_pkg::CH_FIRST_CURRENT &&
            extended_bias_enable_in) begin
            if (mag > state_reg.extended_bias_current) begin
                mag = mag - state_reg.extended_bias_current;
            end else begin
                mag = '0;
            end
        end
        if (sample_in.valid && sample_in.channel == line_monitor_pkg::CH_EXT_BIAS) begin
            state_next.extended_bias_current = mag;
        end
        state_next.stage.valid      = sample_in.valid && cfg.valid;
        state_next.stage.idx        = cfg.idx;
        state_next.stage.signed_fmt = (cfg.polarity == line_monitor_pkg::MAG_SIGNED);
        state_next.stage.sign       = (sample_in.value < 0);
        state_next.stage.magnitude  = mag;
        state_next.stage.recip      = cfg.recip;
        state_next.stage.limit      = cfg.limit;
    end

    // Sample stage register.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Only the read strobe reaches the store; write strobe and data are dropped.
    assign read_map = decode_offset(reg_req_in.addr, power_monitor_select_in);

    measurement_scaler measurement_scaler_inst (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .req_in    (state_reg.stage),
        .write_out (scaled_write)
    );

    // Read data leave the store's output flop directly.
    measurement_store measurement_store_inst (
        .clk_in    (clk_in),
        .rstn_in   (rstn_in),
        .write_in  (scaled_write),
        .read_in   (reg_req_in.read),
        .hit_in    (read_map.hit),
        .idx_in    (read_map.idx),
        .rdata_out (reg_rdata_out)
    );

endmodule

// [verif/line_monitor_readback_assertions.sv]
module line_monitor_readback_assertions (
    input  wire logic                                clk_in,
    input  wire logic                                rstn_in,
    input  wire line_monitor_pkg::reg_req_type        reg_req_in,
    input  wire logic [line_monitor_pkg::CODE_W-1:0] reg_rdata_out,
    input  wire line_monitor_pkg::sample_type         sample_in,
    input  wire logic [line_monitor_pkg::SEL_W-1:0]  power_monitor_select_in,
    input  wire logic                                extended_bias_enable_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic seen_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // Remembers whether any measurement has arrived since reset.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seen_reg <= 1'b0;
        end else if (sample_in.valid) begin
            seen_reg <= 1'b1;
        end
    end

    // A sample of one channel, two cycles without another of it, then a read of its register.
    sequence fresh_s(ch, off);
        sample_in.valid && sample_in.channel == ch
        ##1 !(sample_in.valid && sample_in.channel == ch) [*2]
        ##1 (reg_req_in.read && reg_req_in.addr == off);
    endsequence

    // The read port stays at zero in every cycle that does not follow a read.
    idle_zero_a: assert property (!reg_req_in.read |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read cycle");
    quiet_reset_a: assert property (reg_req_in.read && !seen_reg |=> reg_rdata_out == 8'h00)
        else $error("register not zero before any measurement");
    power_undef_a: assert property (reg_req_in.read
        && reg_req_in.addr == line_monitor_pkg::POWER_OFFSET
        && power_monitor_select_in > line_monitor_pkg::SELECT_LAST |=> reg_rdata_out == 8'h00)
        else $error("power read with undefined pointer not zero");
    loop_v_top_a: assert property (reg_req_in.read
        && reg_req_in.addr == line_monitor_pkg::LOOP_V_OFFSET |=> !reg_rdata_out[7])
        else $error("loop voltage bit 7 set");
    loop_i_top_a: assert property (reg_req_in.read
        && reg_req_in.addr == line_monitor_pkg::LOOP_I_OFFSET |=> !reg_rdata_out[7])
        else $error("loop current bit 7 set");
    loop_v_sign_a: assert property (fresh_s(line_monitor_pkg::CH_LOOP_V,
        line_monitor_pkg::LOOP_V_OFFSET) |=> reg_rdata_out[6] == $past(sample_in.value[23], 4))
        else $error("loop voltage sign bit wrong");
    loop_i_sign_a: assert property (fresh_s(line_monitor_pkg::CH_LOOP_I,
        line_monitor_pkg::LOOP_I_OFFSET) |=> reg_rdata_out[6] == $past(sample_in.value[23], 4))
        else $error("loop current sign bit wrong");
    tip_positive_a: assert property (fresh_s(line_monitor_pkg::CH_TIP_V,
        line_monitor_pkg::TIP_V_OFFSET) |=> $past(sample_in.value[23], 4) || reg_rdata_out == 8'h00)
        else $error("positive tip voltage not read as zero");
endmodule

bind line_monitor_readback line_monitor_readback_assertions line_monitor_readback_assertions_inst (
    .clk_in                  (clk_in),
    .rstn_in                 (rstn_in),
    .reg_req_in              (reg_req_in),
    .reg_rdata_out           (reg_rdata_out),
    .sample_in               (sample_in),
    .power_monitor_select_in (power_monitor_select_in),
    .extended_bias_enable_in (extended_bias_enable_in)
);

// [verif/line_monitor_readback_tb.sv]
module line_monitor_readback_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                                clk_in;
    logic                                rstn_in;
    line_monitor_pkg::reg_req_type       reg_req;
    line_monitor_pkg::sample_type        sample;
    logic [line_monitor_pkg::CODE_W-1:0] rdata;
    logic [line_monitor_pkg::SEL_W-1:0]  sel;
    logic                                bias_en;
    logic [7:0]                          d;
    int                                  err_count;
    int                                  tests_run;

    line_monitor_readback line_monitor_readback_inst (
        .clk_in                  (clk_in),
        .rstn_in                 (rstn_in),
        .reg_req_in              (reg_req),
        .reg_rdata_out           (rdata),
        .sample_in               (sample),
        .power_monitor_select_in (sel),
        .extended_bias_enable_in (bias_en)
    );

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compares a value seen at the port with the expected one.
    task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One read strobe; the data are taken in the cycle after it.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_in);
        reg_req.read <= 1'b1;
        reg_req.addr <= a;
        @(posedge clk_in);
        reg_req.read <= 1'b0;
        #1 q = rdata;
    endtask

    // One write strobe, which the block must ignore.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        reg_req.write <= 1'b1;
        reg_req.addr  <= a;
        reg_req.wdata <= v;
        @(posedge clk_in);
        reg_req.write <= 1'b0;
    endtask

    // One measurement sample of one clock.
    task automatic smp(input line_monitor_pkg::channel_type ch, input int v);
        @(posedge clk_in);
        sample.valid   <= 1'b1;
        sample.channel <= ch;
        sample.value   <= 24'(v);
        @(posedge clk_in);
        sample.valid <= 1'b0;
    endtask

    // Sample, wait until the result is stored, read it back and compare.
    task automatic chk(input line_monitor_pkg::channel_type ch, input int v,
                       input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        smp(ch, v);
        @(posedge clk_in);
        rd(a, q);
        cmp(q, exp);
    endtask

    // Free-running bench clock at 40 MHz.
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    // Cuts a hung run short.
    initial begin
        #50us;
        err_count++;
        stop_test();
    end

    // Main sequence of tests.
    initial begin
        rstn_in   = 1'b0;
        reg_req   = '0;
        sample    = '0;
        sel       = '0;
        bias_en   = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        // Writes everywhere, including both unmapped neighbours, leave zero readings.
        for (int a = 8'h4c; a <= 8'h55; a++) begin
            wr(8'(a), 8'ha5);
            rd(8'(a), d);
            cmp(d, 8'h00);
        end
        $display("test reset_and_writes done");
        chk(line_monitor_pkg::CH_LOOP_V, -3000, 8'h4e, 8'h42);
        chk(line_monitor_pkg::CH_LOOP_V, 94500, 8'h4e, 8'h3f);
        chk(line_monitor_pkg::CH_LOOP_V, 200000, 8'h4e, 8'h3f);
        chk(line_monitor_pkg::CH_LOOP_I, -78750, 8'h4f, 8'h7f);
        chk(line_monitor_pkg::CH_LOOP_I, 3100, 8'h4f, 8'h02);
        chk(line_monitor_pkg::CH_TIP_V, -95880, 8'h50, 8'hff);
        chk(line_monitor_pkg::CH_TIP_V, 5000, 8'h50, 8'h00);
        chk(line_monitor_pkg::CH_TIP_V, -3860, 8'h50, 8'h0a);
        wr(8'h50, 8'h00);
        rd(8'h50, d);
        cmp(d, 8'h0a);
        chk(line_monitor_pkg::CH_RING_V, -3760, 8'h51, 8'h0a);
        chk(line_monitor_pkg::CH_RING_V, -200000, 8'h51, 8'hff);
        chk(line_monitor_pkg::CH_BATTERY_A, -37600, 8'h52, 8'h64);
        chk(line_monitor_pkg::CH_BATTERY_B, -75300, 8'h53, 8'hc8);
        chk(line_monitor_pkg::CH_FIRST_CURRENT, 81345, 8'h54, 8'hff);
        chk(line_monitor_pkg::CH_FIRST_CURRENT, 3290, 8'h54, 8'h0a);
        $display("test scaling done");
        // Each transistor gets a distinct reading; the pointer picks which one is read.
        for (int i = 0; i < 6; i++) begin
            smp(line_monitor_pkg::channel_type'(i),
                10 * (i + 1) * ((i == 2 || i == 3) ? 362 : 3040) + 100);
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            sel <= 3'(i);
            rd(8'h4d, d);
            cmp(d, (i < 6) ? 8'(10 * (i + 1)) : 8'h00);
        end
        @(posedge clk_in);
        sel <= 3'h2;
        chk(line_monitor_pkg::CH_POWER_Q3, 362 * 300, 8'h4d, 8'hff);
        @(posedge clk_in);
        sel <= 3'h0;
        chk(line_monitor_pkg::CH_POWER_Q1, 3040 * 255, 8'h4d, 8'hff);
        $display("test power_pointer done");
        @(posedge clk_in);
        bias_en <= 1'b1;
        smp(line_monitor_pkg::CH_EXT_BIAS, 3190);
        chk(line_monitor_pkg::CH_FIRST_CURRENT, 31900, 8'h54, 8'h5a);
        chk(line_monitor_pkg::CH_FIRST_CURRENT, 3000, 8'h54, 8'h00);
        @(posedge clk_in);
        bias_en <= 1'b0;
        chk(line_monitor_pkg::CH_FIRST_CURRENT, 31900, 8'h54, 8'h64);
        $display("test extended_bias done");
        // A reset in mid-run clears the stored results.
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd(8'h4e, d);
        cmp(d, 8'h00);
        $display("test second_reset done");
        stop_test();
    end
endmodule
